/* File: core/skp_key_stack.sv */
// file: 256 by 5 key stack with sense strobe and inhibit
`timescale 1ns/1ps
module skp_key_stack
  import skp_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  skp_sel_t        sel,
  input  wire logic       strobe,
  input  wire logic       inhibit_gate,
  input  wire logic [4:0] wdata,
  output logic      [4:0] sense
);

  logic [4:0] mem [SKP_DEPTH];
  logic [4:0] rdata;
  logic [4:0] inhibit;
  wire  [7:0] rd_idx = {line_idx(sel.x_rd), line_idx(sel.y_rd)};
  wire  [7:0] wr_idx = {line_idx(sel.x_wr), line_idx(sel.y_wr)};

  function automatic logic [3:0] line_idx(input logic [15:0] lines);
    logic [3:0] r;
    r = 4'h0;
    for (int k = 0; k < SKP_LINES; k++) begin
      if (lines[k]) begin
        r = 4'(k);
      end
    end
    return r;
  endfunction

  // ==========================================================
  // sense and inhibit
  assign sense   = strobe ? rdata : 5'h00;         // see R3
  assign inhibit = {5{inhibit_gate}} & ~wdata;     // see R4 see R5

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= 5'h00;
      for (int k = 0; k < SKP_DEPTH; k++) begin
        mem[k] <= SKP_KEY_RST;
      end
    end else begin
      if (|sel.x_rd) begin
        rdata <= mem[rd_idx];                      // see R24
      end
      if (|sel.x_wr) begin
        mem[wr_idx] <= ~inhibit;                   // see R4 see R24
      end
    end
  end

  // ==========================================================
  // checks
  property p_wr_inhibit;
    @(posedge pclk) disable iff (!presetn)
      (|sel.x_wr) |-> inhibit_gate && $past(inhibit_gate);
  endproperty
  a_wr_inhibit: assert property (p_wr_inhibit) // see R5
    else $error("write current without inhibit lead");

  property p_one_pos;
    @(posedge pclk) disable iff (!presetn)
      (|sel.x_wr) |-> $onehot(sel.x_wr) && $onehot(sel.y_wr);
  endproperty
  a_one_pos: assert property (p_one_pos) // see R2
    else $error("more than one stack position written");

endmodule

/* File: core/skp_pkg.sv */
// package: constants and types of the storage key protection stack
package skp_pkg;

  // ==========================================================
  // register map, byte addresses
  localparam logic [7:0] SKP_CMD_OFF    = 8'h00;
  localparam logic [7:0] SKP_ARG_A_OFF  = 8'h04;
  localparam logic [7:0] SKP_ARG_B_OFF  = 8'h08;
  localparam logic [7:0] SKP_CTRL_OFF   = 8'h0c;
  localparam logic [7:0] SKP_STAT_OFF   = 8'h10;
  localparam logic [7:0] SKP_CLR_OFF    = 8'h14;
  localparam logic [7:0] SKP_KEYS_OFF   = 8'h18;
  localparam logic [7:0] SKP_RESULT_OFF = 8'h1c;
  localparam logic [7:0] SKP_PSWC_OFF   = 8'h20;

  // ==========================================================
  // reset values and fixed codes
  localparam logic [4:0]  SKP_KEY_RST   = 5'h10;
  localparam logic [15:0] SKP_PROT_CODE = 16'h0004;
  localparam logic [2:0]  SKP_MAIN_HI   = 3'h7;
  localparam logic [3:0]  SKP_KEY_ZERO  = 4'h0;
  localparam int          SKP_DEPTH     = 256;
  localparam int          SKP_LINES     = 16;

  // ==========================================================
  // commands, sources, states
  typedef enum logic [2:0] {
    OP_ACCESS  = 3'h0,
    OP_SET_KEY = 3'h1,
    OP_INS_KEY = 3'h2,
    OP_LD_PSW  = 3'h3,
    OP_SEL_GO  = 3'h4,
    OP_MPX_GO  = 3'h5,
    OP_MPX_SEL = 3'h6,
    OP_MPX_END = 3'h7
  } skp_op_t;

  typedef enum logic [1:0] {
    SRC_CPU  = 2'h0,
    SRC_MPX  = 2'h1,
    SRC_SEL1 = 2'h2,
    SRC_SEL2 = 2'h3
  } skp_src_t;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_ADDR  = 6'b000010,
    ST_READ  = 6'b000100,
    ST_INHB  = 6'b001000,
    ST_WRITE = 6'b010000,
    ST_FIN   = 6'b100000
  } skp_state_t;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic       sdata_chk;
    logic [2:0] ucw_hi;
    logic       input_cyc;
    logic       sdr_dest;
    logic       store;
    logic       main;
    skp_src_t   src;
  } skp_ctrl_t;

  typedef struct packed {
    logic [15:0] x_rd;
    logic [15:0] y_rd;
    logic [15:0] x_wr;
    logic [15:0] y_wr;
  } skp_sel_t;

  typedef struct packed {
    logic [1:0] sel_ccc;
    logic [1:0] sel_chk;
    logic       mpx_ind;
    logic [4:0] latch;
    logic       mismatch;
    logic       par_err;
    logic       mach_chk;
    logic       prot_exc;
    logic       busy;
  } skp_status_t;

  typedef struct packed {
    logic [3:0] saved;
    logic [3:0] sel2;
    logic [3:0] sel1;
    logic [3:0] active;
  } skp_keys_t;

endpackage

/* File: core/skp_stack_decode.sv */
// file: x and y select decode of the key stack address
`timescale 1ns/1ps
module skp_stack_decode
  import skp_pkg::*;
(
  input  wire logic [7:0] addr,
  input  wire logic       rd,
  input  wire logic       wr,
  output skp_sel_t        sel
);

  // ==========================================================
  // one line of sixteen per half, gated by direction
  genvar i;
  generate
    for (i = 0; i < SKP_LINES; i++) begin : g_line
      wire x_hit = (addr[7:4] == 4'(i));  // see R1
      wire y_hit = (addr[3:0] == 4'(i));  // see R1
      assign sel.x_rd[i] = x_hit & rd;     // see R2
      assign sel.y_rd[i] = y_hit & rd;     // see R2
      assign sel.x_wr[i] = x_hit & wr;     // see R2
      assign sel.y_wr[i] = y_hit & wr;     // see R2
    end
  endgenerate

endmodule

/* File: core/skp_storage_key_protect.sv */
// file: storage key protection stack control with apb registers
//
// How it works
// R1 - address nibbles pick x and y lines
// R2 - selects gated by read or write control
// R3 - sensed bits taken only under read strobe
// R4 - inhibit drives every zero bit on write
// R5 - inhibit leads and outlasts write current; here inhibit starts a cycle before the write and ends with it
// R6 - latch loaded, then written back same position
// R7 - protection acted on only when storage changes
// R8 - set key: key byte, block by address
// R9 - set key rewrites data, stores new key
// R10 - insert key crosses key into result byte
// R11 - psw load saves key, sets active key
// R12 - selector start keeps channel address key
// R13 - selector mismatch only on input cycles
// R14 - multiplexor start writes key to subchannel
// R15 - multiplexor select loads key, later restore
// R16 - exception: mismatch or parity, key nonzero
// R17 - only stores or sdr, main storage only
// R18 - cpu trap code four; io status bit
// R19 - selector check latch, interrupt, status bit
// R20 - latch key and parity, check parity
// R21 - odd parity, even means error
// R22 - machine check beats protection trap
// R23 - main access forces high address bits
// R24 - synchronous stack, read then write back
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module skp_storage_key_protect
  import skp_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             prot_trap,
  output logic             mach_trap,
  output logic      [1:0]  sel_irq
);

  skp_state_t  state;
  skp_state_t  next_state;
  skp_op_t     op;
  skp_ctrl_t   ctrl;
  skp_sel_t    sel;
  skp_status_t stat;
  skp_keys_t   keys;
  logic [31:0] arg_a;
  logic [31:0] arg_b;
  logic [31:0] insert_result;
  logic [15:0] old_psw_code;
  logic [7:0]  stack_addr_reg;
  logic [4:0]  key_read_latch;
  logic [4:0]  next_latch;
  logic [4:0]  sense;
  logic [3:0]  active_key_latch;
  logic [3:0]  saved_cpu_key_slot;
  logic [3:0]  selector_one_key_reg;
  logic [3:0]  selector_two_key_reg;
  logic [3:0]  mpx_temp_key;
  logic [3:0]  mpx_hold_key;
  logic [1:0]  sel_chk;
  logic [1:0]  sel_ccc;
  logic        mpx_ind;
  logic        prot_exc;
  logic        mach_chk;
  logic        last_par;
  logic        last_mism;

  function automatic logic odd_par(input logic [3:0] k);
    return ~^k;
  endfunction

  function automatic logic [3:0] chan_key(
    input skp_src_t   s,
    input logic [3:0] act,
    input logic [3:0] k1,
    input logic [3:0] k2
  );
    logic [3:0] r;
    r = act;
    case (s)
      SRC_SEL1: r = k1;
      SRC_SEL2: r = k2;
      default:  r = act;
    endcase
    return r;
  endfunction

  // ==========================================================
  // apb slave decode
  wire acc_ph   = psel & penable;
  wire wr_acc   = acc_ph & pwrite;
  wire hit_cmd  = paddr == SKP_CMD_OFF;
  wire hit_a    = paddr == SKP_ARG_A_OFF;
  wire hit_b    = paddr == SKP_ARG_B_OFF;
  wire hit_ctrl = paddr == SKP_CTRL_OFF;
  wire hit_stat = paddr == SKP_STAT_OFF;
  wire hit_clr  = paddr == SKP_CLR_OFF;
  wire hit_keys = paddr == SKP_KEYS_OFF;
  wire hit_res  = paddr == SKP_RESULT_OFF;
  wire hit_pswc = paddr == SKP_PSWC_OFF;
  wire hit_any  = hit_cmd | hit_a | hit_b | hit_ctrl | hit_stat
                | hit_clr | hit_keys | hit_res | hit_pswc;
  wire st_idle  = state == ST_IDLE;
  wire st_addr  = state == ST_ADDR;
  wire st_read  = state == ST_READ;
  wire st_inhb  = state == ST_INHB;
  wire st_write = state == ST_WRITE;
  wire st_fin   = state == ST_FIN;
  wire go       = wr_acc & hit_cmd & st_idle;
  wire arg_we   = wr_acc & st_idle;
  wire [4:0] clr_bits = (wr_acc & hit_clr) ? pwdata[4:0] : 5'h00;

  assign pready  = 1'b1;
  assign pslverr = acc_ph & ~hit_any;

  assign stat = '{sel_ccc: sel_ccc, sel_chk: sel_chk,
                  mpx_ind: mpx_ind, latch: key_read_latch,
                  mismatch: last_mism, par_err: last_par,
                  mach_chk: mach_chk, prot_exc: prot_exc,
                  busy: ~st_idle};
  assign keys = '{saved: saved_cpu_key_slot,
                  sel2: selector_two_key_reg,
                  sel1: selector_one_key_reg,
                  active: active_key_latch};

  wire [31:0] rd_mux = hit_a    ? arg_a :
                  hit_b    ? arg_b :
                  hit_ctrl ? 32'(ctrl) :
                  hit_stat ? 32'(stat) :
                  hit_keys ? 32'(keys) :
                  hit_res  ? insert_result :
                  hit_pswc ? {16'h0000, old_psw_code} :
                  32'h0000_0000;

  // ==========================================================
  // sequencer
  wire new_op_stack = (skp_op_t'(pwdata[2:0]) != OP_LD_PSW)
                    & (skp_op_t'(pwdata[2:0]) != OP_SEL_GO)
                    & (skp_op_t'(pwdata[2:0]) != OP_MPX_END);

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:  next_state = go ? (new_op_stack ? ST_ADDR : ST_FIN)
                                : ST_IDLE;
      ST_ADDR:  next_state = ST_READ;
      ST_READ:  next_state = ST_INHB;
      ST_INHB:  next_state = ST_WRITE;
      ST_WRITE: next_state = ST_FIN;
      ST_FIN:   next_state = ST_IDLE;
      default:  next_state = ST_IDLE;
    endcase
  end

  // ==========================================================
  // stack address and key latch
  wire main_op = (skp_op_t'(pwdata[2:0]) == OP_SET_KEY)
               | (skp_op_t'(pwdata[2:0]) == OP_INS_KEY)
               | ((skp_op_t'(pwdata[2:0]) == OP_ACCESS) & ctrl.main);
  wire [7:0] next_sa =
    main_op ? {SKP_MAIN_HI, arg_a[15:11]} :           // see R23 see R8
    (skp_op_t'(pwdata[2:0]) == OP_MPX_GO)  ? arg_b[7:0] :  // see R14
    (skp_op_t'(pwdata[2:0]) == OP_MPX_SEL) ? arg_a[7:0] :  // see R15
    {ctrl.ucw_hi, arg_a[4:0]};
  wire [3:0] new_key = arg_b[7:4];                     // see R8

  always_comb begin
    next_latch = sense;                                // see R20
    case (op)
      OP_SET_KEY: next_latch = {odd_par(new_key), new_key};  // see R9
      OP_MPX_GO:  next_latch = {odd_par(mpx_temp_key),
                                mpx_temp_key};               // see R14
      default:    next_latch = sense;
    endcase
  end

  skp_stack_decode u_decode (
    .addr (stack_addr_reg),
    .rd   (st_addr),
    .wr   (st_write),
    .sel  (sel)
  );

  skp_key_stack u_stack (
    .pclk         (pclk),
    .presetn      (presetn),
    .sel          (sel),
    .strobe       (st_read),
    .inhibit_gate (st_inhb | st_write),
    .wdata        (key_read_latch),
    .sense        (sense)
  );

  // ==========================================================
  // protection checks
  wire [3:0] cur_key = chan_key(ctrl.src, active_key_latch,
                                selector_one_key_reg,
                                selector_two_key_reg);
  wire is_sel   = ctrl.src == SRC_SEL1 || ctrl.src == SRC_SEL2;
  wire par_err  = ~^key_read_latch;                     // see R21
  wire mismatch = cur_key != key_read_latch[3:0];
  wire key_nz   = cur_key != SKP_KEY_ZERO;
  wire checked  = st_write & (op == OP_ACCESS) & ctrl.main;  // see R17
  wire allow    = is_sel ? ctrl.input_cyc                     // see R13
                         : (ctrl.store | ctrl.sdr_dest);      // see R7
  wire exc      = checked & (mismatch | par_err) & key_nz
                & allow;                                       // see R16
  wire mchk     = checked & ~is_sel
                & ((par_err & key_nz & allow) | ctrl.sdata_chk); // see R20
  wire cchk     = checked & is_sel & par_err & key_nz & allow;
  wire cpu_trap = exc & (ctrl.src == SRC_CPU) & ~mchk;        // see R22
  wire [1:0] sel_set = {2{exc & is_sel}}
                     & {ctrl.src == SRC_SEL2, ctrl.src == SRC_SEL1};
  wire [1:0] ccc_set = {2{cchk}}
                     & {ctrl.src == SRC_SEL2, ctrl.src == SRC_SEL1};

  assign sel_irq = sel_chk | sel_ccc;                         // see R19

  // ==========================================================
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      op    <= OP_ACCESS;
    end else begin
      state <= next_state;
      if (go) begin
        op <= skp_op_t'(pwdata[2:0]);
      end
    end
  end

  // read data launched at the end of the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= rd_mux;
    end else begin
      prdata <= 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arg_a <= 32'h0000_0000;
      arg_b <= 32'h0000_0000;
      ctrl  <= '0;
    end else begin
      if (arg_we & hit_a) begin
        arg_a <= pwdata;
      end
      if (arg_we & hit_b) begin
        arg_b <= pwdata;
      end
      if (arg_we & hit_ctrl) begin
        ctrl <= skp_ctrl_t'(pwdata[9:0]);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_addr_reg <= 8'h00;
      key_read_latch <= SKP_KEY_RST;
      mpx_temp_key   <= 4'h0;
      mpx_hold_key   <= 4'h0;
      insert_result  <= 32'h0000_0000;
    end else begin
      if (go) begin
        stack_addr_reg <= next_sa;                      // see R23
        mpx_temp_key   <= arg_a[31:28];                 // see R14
      end
      if (st_read) begin
        key_read_latch <= next_latch;                   // see R6 see R3
      end
      if (st_write && op == OP_MPX_SEL) begin
        mpx_hold_key <= key_read_latch[3:0];            // see R15
      end
      if (st_write && op == OP_INS_KEY) begin
        insert_result <= {arg_b[31:8], key_read_latch[3:0],
                          4'h0};                         // see R10
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_key_latch     <= 4'h0;
      saved_cpu_key_slot   <= 4'h0;
      selector_one_key_reg <= 4'h0;
      selector_two_key_reg <= 4'h0;
    end else if (st_fin) begin
      case (op)
        OP_LD_PSW: begin
          saved_cpu_key_slot <= arg_a[23:20];           // see R11
          active_key_latch   <= arg_a[23:20];           // see R11
        end
        OP_SEL_GO: begin
          if (ctrl.src == SRC_SEL2) begin
            selector_two_key_reg <= arg_a[31:28];       // see R12
          end else begin
            selector_one_key_reg <= arg_a[31:28];       // see R12
          end
        end
        OP_MPX_SEL: active_key_latch <= mpx_hold_key;   // see R15
        OP_MPX_END: active_key_latch <= saved_cpu_key_slot; // see R15
        default:    active_key_latch <= active_key_latch;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prot_exc     <= 1'b0;
      mach_chk     <= 1'b0;
      last_par     <= 1'b0;
      last_mism    <= 1'b0;
      prot_trap    <= 1'b0;
      mach_trap    <= 1'b0;
      old_psw_code <= 16'h0000;
      sel_chk      <= 2'b00;
      sel_ccc      <= 2'b00;
      mpx_ind      <= 1'b0;
    end else begin
      prot_trap <= cpu_trap;                            // see R18
      mach_trap <= mchk;                                // see R22
      if (go) begin
        prot_exc  <= 1'b0;
        mach_chk  <= 1'b0;
        last_par  <= 1'b0;
        last_mism <= 1'b0;
      end else if (checked) begin
        prot_exc  <= exc;
        mach_chk  <= mchk;
        last_par  <= par_err;
        last_mism <= mismatch;
      end
      if (cpu_trap) begin
        old_psw_code <= SKP_PROT_CODE;                  // see R18
      end
      sel_chk <= sel_set | (sel_chk & ~clr_bits[1:0]);  // see R19
      sel_ccc <= ccc_set | (sel_ccc & ~clr_bits[3:2]);
      mpx_ind <= (exc & (ctrl.src == SRC_MPX))
               | (mpx_ind & ~clr_bits[4]);              // see R18
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_main_addr;
    go && main_op |=> stack_addr_reg[7:5] == SKP_MAIN_HI;
  endproperty
  a_main_addr: assert property (p_main_addr) // see R23
    else $error("main access address high bits not forced");

  property p_writeback;
    st_write |=> u_stack.mem[stack_addr_reg] == $past(key_read_latch);
  endproperty
  a_writeback: assert property (p_writeback) // see R6
    else $error("write back not from key latch");

  property p_ldpsw;
    go && skp_op_t'(pwdata[2:0]) == OP_LD_PSW
      |=> ##1 active_key_latch == saved_cpu_key_slot
      && active_key_latch == arg_a[23:20];
  endproperty
  a_ldpsw: assert property (p_ldpsw) // see R11
    else $error("psw key not loaded");

  property p_cpu_trap;
    checked && ctrl.src == SRC_CPU && key_nz && mismatch
      && ctrl.store && !ctrl.sdata_chk && !par_err
      |=> prot_trap && old_psw_code == SKP_PROT_CODE;
  endproperty
  a_cpu_trap: assert property (p_cpu_trap) // see R16
    else $error("cpu protection trap missed");

  property p_no_store;
    checked && !is_sel && !ctrl.store && !ctrl.sdr_dest
      |=> !prot_trap && !prot_exc;
  endproperty
  a_no_store: assert property (p_no_store) // see R7
    else $error("protection acted on without store");

  property p_key_zero;
    checked && !key_nz && !ctrl.sdata_chk |=> !prot_exc && !mach_trap;
  endproperty
  a_key_zero: assert property (p_key_zero) // see R20
    else $error("key zero still raised a check");

  property p_priority;
    checked && exc && mchk |=> mach_trap && !prot_trap;
  endproperty
  a_priority: assert property (p_priority) // see R22
    else $error("protection trap taken with machine check");

  property p_sel_input;
    $rose(sel_chk[0]) |-> $past(ctrl.input_cyc && is_sel);
  endproperty
  a_sel_input: assert property (p_sel_input) // see R13
    else $error("selector check without input cycle");

  property p_local;
    st_write && !ctrl.main |=> !prot_exc && !mach_chk;
  endproperty
  a_local: assert property (p_local) // see R17
    else $error("check raised on local store access");

  c_cpu_trap: cover property (prot_trap);
  c_sel_chk:  cover property ($rose(sel_chk[1]));
  c_mpx_sel:  cover property (st_fin && op == OP_MPX_SEL);
  c_both:     cover property (checked && exc && mchk);

endmodule

/* File: sim/skp_cpu_model.sv */
// cpu side apb master model driving the key stack registers
`timescale 1ns/1ps
module skp_cpu_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // ========================================
  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // ========================================
  // one transfer, held until pready sampled
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

/* File: sim/skp_storage_key_protect_stack_bench.sv */
// self-checking bench of the storage key protection stack
`timescale 1ns/1ps
module skp_storage_key_protect_stack_bench
  import skp_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        prot_trap;
  logic        mach_trap;
  logic [1:0]  sel_irq;
  logic [31:0] rv;
  logic        err;
  int          fail_count;
  int          n_checks;
  int          n_prot;
  int          n_mach;
  int          cyc;

  skp_storage_key_protect dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .prot_trap, .mach_trap,
    .sel_irq);
  skp_cpu_model m (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr);

  // ========================================
  // clock, trap counters, timeout
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (prot_trap === 1'b1) n_prot++;
    if (mach_trap === 1'b1) n_mach++;
    cyc++;
    if (cyc > 5000) begin
      fail_count++;
      results();
    end
  end

  // ========================================
  // helpers
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    m.xfer(1'b1, a, d, rv, err);
  endtask
  task rd(input logic [7:0] a);
    m.xfer(1'b0, a, 32'h0000_0000, rv, err);
  endtask
  task cmd(input skp_op_t op, input logic [31:0] a, input logic [31:0] b,
           input logic [9:0] c);
    int i;
    wr(SKP_ARG_A_OFF, a);
    wr(SKP_ARG_B_OFF, b);
    wr(SKP_CTRL_OFF, {22'h0, c});
    n_prot = 0;
    n_mach = 0;
    wr(SKP_CMD_OFF, {29'h0, op});
    for (i = 0; i < 40; i++) begin
      rd(SKP_STAT_OFF);
      if (rv[0] === 1'b0) break;
    end
    chk("idle", 32'h0000_0000, {31'h0, rv[0]});
  endtask
  task results();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ========================================
  // scenarios
  task t_reset();
    rd(SKP_KEYS_OFF);
    chk("keys", 32'h0000_0000, rv);
    rd(8'h24);
    chk("slverr", 32'h0000_0001, {31'h0, err});
    $display("test reset done");
  endtask
  task t_keys();
    cmd(OP_SET_KEY, 32'h0000_1800, 32'h0000_0050, 10'h004);
    cmd(OP_ACCESS, 32'h0000_1800, 32'h0000_0000, 10'h00c);
    chk("key zero", 32'h0000_0000, n_prot);
    cmd(OP_LD_PSW, 32'h0050_0000, 32'h0000_0000, 10'h000);
    rd(SKP_KEYS_OFF);
    chk("psw key", 32'h0000_5005, rv);
    cmd(OP_INS_KEY, 32'h0000_1800, 32'haabb_ccff, 10'h004);
    rd(SKP_RESULT_OFF);
    chk("insert", 32'haabb_cc50, rv);
    rd(SKP_STAT_OFF);
    chk("latch", 32'h0000_0015, {27'h0, rv[9:5]});
    $display("test keys done");
  endtask
  task t_prot();
    cmd(OP_ACCESS, 32'h0000_2000, 32'h0000_0000, 10'h00c);
    chk("prot", 32'h0000_0001, n_prot);
    rd(SKP_PSWC_OFF);
    chk("code", {16'h0, SKP_PROT_CODE}, rv);
    cmd(OP_ACCESS, 32'h0000_2000, 32'h0000_0000, 10'h004);
    chk("fetch", 32'h0000_0000, n_prot);
    cmd(OP_ACCESS, 32'h0000_2000, 32'h0000_0000, 10'h008);
    chk("local", 32'h0000_0000, n_prot);
    cmd(OP_ACCESS, 32'h0000_2000, 32'h0000_0000, 10'h014);
    chk("sdr", 32'h0000_0001, n_prot);
    cmd(OP_ACCESS, 32'h0000_1800, 32'h0000_0000, 10'h00c);
    chk("match", 32'h0000_0000, n_prot);
    cmd(OP_ACCESS, 32'h0000_2000, 32'h0000_0000, 10'h20c);
    chk("mach", 32'h0000_0001, n_mach);
    chk("no prot", 32'h0000_0000, n_prot);
    cmd(OP_INS_KEY, 32'h0000_1800, 32'h0000_0000, 10'h004);
    rd(SKP_RESULT_OFF);
    chk("kept", 32'h0000_0050, rv);
    $display("test protection done");
  endtask
  task t_sel();
    cmd(OP_SEL_GO, 32'h7000_0000, 32'h0000_0000, 10'h002);
    rd(SKP_KEYS_OFF);
    chk("sel key", 32'h0000_5075, rv);
    cmd(OP_ACCESS, 32'h0000_1800, 32'h0000_0000, 10'h00e);
    chk("sel out", 32'h0000_0000, {30'h0, sel_irq});
    cmd(OP_ACCESS, 32'h0000_1800, 32'h0000_0000, 10'h02e);
    chk("sel in", 32'h0000_0001, {30'h0, sel_irq});
    chk("bit43", 32'h0000_0001, {31'h0, rv[11]});
    wr(SKP_CLR_OFF, 32'h0000_0001);
    rd(SKP_STAT_OFF);
    chk("cleared", 32'h0000_0000, {30'h0, sel_irq});
    cmd(OP_SEL_GO, 32'h3000_0000, 32'h0000_0000, 10'h003);
    cmd(OP_ACCESS, 32'h0000_1800, 32'h0000_0000, 10'h02f);
    chk("sel2 in", 32'h0000_0002, {30'h0, sel_irq});
    $display("test selector done");
  endtask
  task t_mpx();
    cmd(OP_MPX_GO, 32'h6000_0000, 32'h0000_0005, 10'h001);
    cmd(OP_MPX_SEL, 32'h0000_0005, 32'h0000_0000, 10'h001);
    rd(SKP_KEYS_OFF);
    chk("mpx key", 32'h0000_0006, {28'h0, rv[3:0]});
    cmd(OP_MPX_END, 32'h0000_0000, 32'h0000_0000, 10'h001);
    rd(SKP_KEYS_OFF);
    chk("restore", 32'h0000_0005, {28'h0, rv[3:0]});
    cmd(OP_ACCESS, 32'h0000_2000, 32'h0000_0000, 10'h00d);
    chk("ucw ind", 32'h0000_0001, {31'h0, rv[10]});
    chk("mpx trap", 32'h0000_0000, n_prot);
    $display("test multiplexor done");
  endtask

  // ========================================
  // main sequence
  initial begin
    presetn = 1'b0;
    fail_count = 0;
    n_checks = 0;
    n_prot = 0;
    n_mach = 0;
    cyc = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_keys();
    t_prot();
    t_sel();
    t_mpx();
    results();
  end
endmodule
